// ===== hw/spi_class.sv
// power class decision: whether full supply current is not yet allowed
`timescale 1ns/10ps
module spi_class (
  // usb status
  input wire spi_pkg::spi_usb_stat_s stat_i,
  // decision
  output logic limit_o
);
  import spi_pkg::*;

  logic high_power; // above one unit load
  always_comb begin
    // 2 mA steps compared directly against limit in same units
    high_power = (stat_i.max_power > UNIT_LOAD_LIMIT);
    if (high_power) begin
      limit_o = stat_i.suspended | ~stat_i.configured;
    end else begin
      limit_o = stat_i.suspended;
    end
  end
endmodule : spi_class

// ===== hw/spi_pkg.sv
// package for the supply limit indicator block
package spi_pkg;

  // ----------------------------------------------------------------------
  // power classification
  // ----------------------------------------------------------------------
  // descriptor max power field width, counted in 2 mA steps
  localparam int unsigned MAXPWR_W = 8;
  // one unit load limit, 100 mA expressed in 2 mA steps
  localparam logic [7:0] UNIT_LOAD_LIMIT = 8'h32;
  localparam int unsigned MA_PER_STEP = 2;

  // ----------------------------------------------------------------------
  // sampling timing
  // ----------------------------------------------------------------------
  localparam int unsigned CLK_PERIOD_NS = 8;
  // time the pin is released and allowed to settle before sampling
  localparam int unsigned SETTLE_NS = 64;
  localparam int unsigned SETTLE_CYC =
    (SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned CNT_W = 4;
  // polarity taken before the first sample completes
  localparam logic POL_RESET = 1'b1;

  // ----------------------------------------------------------------------
  // carrier for the usb core status
  // ----------------------------------------------------------------------
  typedef struct packed {
    logic suspended;  // link in suspend
    logic configured; // host has set a configuration
    logic bus_reset;  // usb bus reset in progress (level)
    logic [7:0] max_power; // descriptor max power, 2 mA units
  } spi_usb_stat_s;

  // sampler states
  typedef enum logic [2:0] {
    SP_SETTLE = 3'b001,
    SP_DRIVE = 3'b010,
    SP_HOLD = 3'b100
  } spi_samp_e;

endpackage : spi_pkg

// ===== hw/spi_top.sv
// supply limit indicator top: strap sampling and pin drive
`timescale 1ns/10ps
// Contract
// - low power: assert only while suspended
// - high power: assert suspended or unconfigured
// - deassert when full current is allowed
// - sample pin at power-up and bus reset
// - pull-up strap: asserted level is high
// - pull-down strap: asserted level is low
// - max power counted in 2 mA steps
module spi_top (
  // clock and reset
  input wire logic MCLK_I,
  input wire logic RSTN_I,
  // usb core status
  input wire spi_pkg::spi_usb_stat_s USB_STAT_I,
  // indicator pin, three signals
  input wire logic SUPPLY_LIMIT_INDICATOR_I,
  output logic SUPPLY_LIMIT_INDICATOR_O,
  output logic SUPPLY_LIMIT_INDICATOR_OEN_O,
  // debug view of latched polarity
  output logic POLARITY_O
);
  import spi_pkg::*;

  // ----------------------------------------------------------------------
  // declarations
  // ----------------------------------------------------------------------
  spi_samp_e state_r; // sampler state
  logic [CNT_W-1:0] cnt_r; // settle counter
  logic pol_r; // asserted level of the indicator
  logic limit; // current decision from class logic
  logic rst_seen_r; // bus reset edge tracking
  logic rst_rise; // new bus reset start

  // ----------------------------------------------------------------------
  // power class
  // ----------------------------------------------------------------------
  spi_class u_class (
    .stat_i(USB_STAT_I),
    .limit_o(limit)
  );

  // bus reset start detection; input is synchronous so no synchroniser
  assign rst_rise = USB_STAT_I.bus_reset & ~rst_seen_r;
  always_ff @(posedge MCLK_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      rst_seen_r <= 1'b0;
    end else begin
      rst_seen_r <= USB_STAT_I.bus_reset;
    end
  end

  // ----------------------------------------------------------------------
  // sampler: release pin, let strap settle, catch level
  // ----------------------------------------------------------------------
  // power-up enters settle straight from reset; a bus reset re-enters it
  always_ff @(posedge MCLK_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      state_r <= SP_SETTLE;
      cnt_r <= '0;
    end else begin
      unique case (state_r)
        SP_SETTLE: begin
          // counting while pin floats to the strap level
          if (cnt_r == CNT_W'(SETTLE_CYC - 1)) begin
            state_r <= SP_DRIVE;
            cnt_r <= '0;
          end else begin
            cnt_r <= cnt_r + CNT_W'(1);
          end
        end
        SP_DRIVE, SP_HOLD: begin
          state_r <= SP_DRIVE;
          if (rst_rise) begin
            state_r <= SP_SETTLE;
            cnt_r <= '0;
          end
        end
        default: begin
          state_r <= SP_SETTLE;
          cnt_r <= '0;
        end
      endcase
    end
  end

  // polarity latch: only written at the end of a settle window
  always_ff @(posedge MCLK_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      pol_r <= POL_RESET;
    end else if (state_r == SP_SETTLE &&
                 cnt_r == CNT_W'(SETTLE_CYC - 1)) begin
      // pull-up reads high, pull-down reads low
      pol_r <= SUPPLY_LIMIT_INDICATOR_I;
    end
  end

  // ----------------------------------------------------------------------
  // pin drive
  // ----------------------------------------------------------------------
  // enable is low while driving; released during the settle window
  always_ff @(posedge MCLK_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      SUPPLY_LIMIT_INDICATOR_OEN_O <= 1'b1;
      SUPPLY_LIMIT_INDICATOR_O <= 1'b0;
    end else if (state_r == SP_DRIVE && !rst_rise) begin
      SUPPLY_LIMIT_INDICATOR_OEN_O <= 1'b0;
      // asserted shows pol, deasserted shows its inverse
      SUPPLY_LIMIT_INDICATOR_O <= limit ? pol_r : ~pol_r;
    end else begin
      SUPPLY_LIMIT_INDICATOR_OEN_O <= 1'b1;
      SUPPLY_LIMIT_INDICATOR_O <= 1'b0;
    end
  end

  // polarity visible for observation
  always_ff @(posedge MCLK_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      POLARITY_O <= POL_RESET;
    end else begin
      POLARITY_O <= pol_r;
    end
  end

  // ----------------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------------
  property p_low_class;
    @(posedge MCLK_I) disable iff (!RSTN_I)
    (state_r == SP_DRIVE && !rst_rise &&
     USB_STAT_I.max_power <= UNIT_LOAD_LIMIT)
    |=> (SUPPLY_LIMIT_INDICATOR_O ==
         ($past(USB_STAT_I.suspended) ? pol_r : ~pol_r));
  endproperty
  a_low_class: assert property (p_low_class)
    else $error("low power class indicator wrong");

  property p_high_class;
    @(posedge MCLK_I) disable iff (!RSTN_I)
    (state_r == SP_DRIVE && !rst_rise &&
     USB_STAT_I.max_power > UNIT_LOAD_LIMIT &&
     (USB_STAT_I.suspended || !USB_STAT_I.configured))
    |=> SUPPLY_LIMIT_INDICATOR_O == pol_r;
  endproperty
  a_high_class: assert property (p_high_class)
    else $error("high power class not asserted");

  property p_deassert;
    @(posedge MCLK_I) disable iff (!RSTN_I)
    (state_r == SP_DRIVE && !rst_rise && !USB_STAT_I.suspended &&
     USB_STAT_I.configured)
    |=> SUPPLY_LIMIT_INDICATOR_O == ~pol_r;
  endproperty
  a_deassert: assert property (p_deassert)
    else $error("indicator asserted when current allowed");

  sequence s_reset_start;
    rst_rise;
  endsequence
  sequence s_released;
    SUPPLY_LIMIT_INDICATOR_OEN_O [*2];
  endsequence
  property p_sample_on_reset;
    @(posedge MCLK_I) disable iff (!RSTN_I)
    s_reset_start |=> s_released;
  endproperty
  a_sample_on_reset: assert property (p_sample_on_reset)
    else $error("pin not released for sampling at bus reset");

  property p_pull_up;
    @(posedge MCLK_I) disable iff (!RSTN_I)
    (state_r == SP_SETTLE && cnt_r == CNT_W'(SETTLE_CYC - 1) &&
     SUPPLY_LIMIT_INDICATOR_I) |=> pol_r;
  endproperty
  a_pull_up: assert property (p_pull_up)
    else $error("pull-up strap not latched high");

  property p_pull_down;
    @(posedge MCLK_I) disable iff (!RSTN_I)
    (state_r == SP_SETTLE && cnt_r == CNT_W'(SETTLE_CYC - 1) &&
     !SUPPLY_LIMIT_INDICATOR_I) |=> !pol_r;
  endproperty
  a_pull_down: assert property (p_pull_down)
    else $error("pull-down strap not latched low");

  property p_hold_pol;
    @(posedge MCLK_I) disable iff (!RSTN_I)
    (state_r == SP_DRIVE) |=> $stable(pol_r);
  endproperty
  a_hold_pol: assert property (p_hold_pol)
    else $error("polarity changed outside sampling");

  property p_step_units;
    @(posedge MCLK_I) disable iff (!RSTN_I)
    (state_r == SP_DRIVE && !rst_rise &&
     USB_STAT_I.max_power == UNIT_LOAD_LIMIT + 8'h01 &&
     !USB_STAT_I.configured) |=> SUPPLY_LIMIT_INDICATOR_O == pol_r;
  endproperty
  a_step_units: assert property (p_step_units)
    else $error("one step above unit load not classed as high power");

  // pin must float the whole window, or the strap reads our own drive
  sequence s_floating;
    SUPPLY_LIMIT_INDICATOR_OEN_O && !SUPPLY_LIMIT_INDICATOR_O;
  endsequence
  property p_settle_float;
    @(posedge MCLK_I) disable iff (!RSTN_I)
    (state_r == SP_SETTLE) |=> s_floating;
  endproperty
  a_settle_float: assert property (p_settle_float)
    else $error("pin driven during strap settle window");

  // a stray latch write would flip the suspend level mid-session
  property p_pol_only_sampling;
    @(posedge MCLK_I) disable iff (!RSTN_I)
    !(state_r == SP_SETTLE && cnt_r == CNT_W'(SETTLE_CYC - 1))
    |=> $stable(pol_r);
  endproperty
  a_pol_only_sampling: assert property (p_pol_only_sampling)
    else $error("polarity changed away from a sampling point");

  // observation output trails the latch by exactly one edge
  property p_pol_view;
    @(posedge MCLK_I) disable iff (!RSTN_I)
    1'b1 |=> POLARITY_O == $past(pol_r);
  endproperty
  a_pol_view: assert property (p_pol_view)
    else $error("polarity view does not follow latch");

endmodule : spi_top

// ===== verif/spi_strap_model.sv
// board strap resistor model for the supply limit indicator pin
`timescale 1ns/10ps
module spi_strap_model (
  // strap choice: 1 = pull-up fitted, 0 = pull-down fitted
  input wire logic pull_up_i,
  // device side of the pin
  input wire logic pin_drv_i,
  input wire logic pin_oen_i,
  // resolved pin level
  output logic pin_o
);
  // a released pin settles to the strap level; the device wins when it
  // drives, since the strap is a weak resistor
  assign pin_o = pin_oen_i ? pull_up_i : pin_drv_i;
endmodule : spi_strap_model

// ===== verif/testbench.sv
// self-checking bench for the supply limit indicator
`timescale 1ns/10ps
module testbench;
  import spi_pkg::*;
  // ----------------------------------------------------------------
  // signals
  // ----------------------------------------------------------------
  logic mclk; // 125 MHz clock
  logic rstn; // async reset, active low
  spi_usb_stat_s stat; // usb core status
  logic pull_up; // strap fitted on the board
  logic pin_lvl; // resolved pin level
  logic ind_o;
  logic ind_oen;
  logic pol_o;
  int failures = 0;
  int comparisons = 0;
  int cycles = 0;

  spi_top dut_u (
    .MCLK_I(mclk),
    .RSTN_I(rstn),
    .USB_STAT_I(stat),
    .SUPPLY_LIMIT_INDICATOR_I(pin_lvl),
    .SUPPLY_LIMIT_INDICATOR_O(ind_o),
    .SUPPLY_LIMIT_INDICATOR_OEN_O(ind_oen),
    .POLARITY_O(pol_o)
  );

  spi_strap_model strap_u (
    .pull_up_i(pull_up),
    .pin_drv_i(ind_o),
    .pin_oen_i(ind_oen),
    .pin_o(pin_lvl)
  );

  // ----------------------------------------------------------------
  // clock and hang guard
  // ----------------------------------------------------------------
  initial begin
    mclk = 1'b0;
    forever #4 mclk = ~mclk;
  end

  // the whole run needs well under a thousand cycles
  always @(posedge mclk) begin
    cycles++;
    if (cycles == 3000) begin
      failures++;
      give_verdict();
    end
  end

  // ----------------------------------------------------------------
  // shared tasks
  // ----------------------------------------------------------------
  task automatic chk(input logic got, input logic exp);
    comparisons++;
    if (got !== exp) begin
      failures++;
      $display("wrong value at %0t: got %0h expected %0h", $time, got, exp);
    end
  endtask : chk

  task automatic give_verdict();
    if (failures == 0 && comparisons > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : give_verdict

  // apply a status and let the registered outputs settle
  task automatic apply(input logic s, input logic c, input logic [7:0] mp);
    @(posedge mclk);
    stat <= '{suspended: s, configured: c, bus_reset: 1'b0, max_power: mp};
    repeat (3) @(posedge mclk);
    #1;
  endtask : apply

  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  // every suspend/configure mix on both sides of the 100 mA boundary
  task automatic t_classes(input logic pol);
    logic [7:0] mp [4] = '{8'h00, 8'h32, 8'h33, 8'hFF};
    logic lim;
    for (int i = 0; i < 16; i++) begin
      apply(i[0], i[1], mp[i[3:2]]);
      // current counted in 2 mA steps against one unit load
      lim = i[0] | ((int'(mp[i[3:2]]) * MA_PER_STEP > 100) & !i[1]);
      chk(ind_oen, 1'b0);
      chk(ind_o, lim ? pol : ~pol);
      chk(pol_o, pol);
    end
  endtask : t_classes

  // strap swapped while driving, then a held bus reset resamples it
  task automatic t_resample(input logic strap);
    logic old;
    old = pol_o;
    @(posedge mclk);
    pull_up <= strap;
    repeat (4) @(posedge mclk);
    #1;
    chk(pol_o, old);
    @(posedge mclk);
    stat.bus_reset <= 1'b1;
    repeat (2) @(posedge mclk);
    #1;
    chk(ind_oen, 1'b1);
    chk(ind_o, 1'b0);
    // level still high here: no second sample may start
    repeat (14) @(posedge mclk);
    #1;
    chk(ind_oen, 1'b0);
    chk(pol_o, strap);
    @(posedge mclk);
    stat.bus_reset <= 1'b0;
    t_classes(strap);
  endtask : t_resample

  // ----------------------------------------------------------------
  // main sequence: power up on a pull-down so the reset default of 1
  // cannot pass for a real sample
  // ----------------------------------------------------------------
  initial begin
    rstn = 1'b0;
    stat = '0;
    pull_up = 1'b0;
    repeat (7) @(posedge mclk);
    #1;
    chk(ind_oen, 1'b1);
    chk(ind_o, 1'b0);
    chk(pol_o, POL_RESET);
    @(posedge mclk);
    rstn <= 1'b1;
    repeat (12) @(posedge mclk);
    #1;
    chk(pol_o, 1'b0);
    t_classes(1'b0);
    t_resample(1'b1);
    t_resample(1'b0);
    give_verdict();
  end
endmodule : testbench
